// [verilog/pmx_pin_mux.sv]
// Purpose: pin ownership, output routing, pin DMA triggers and sleep gating of port interrupts
// Assumes: configuration inputs are synchronous to clk; pads arrive asynchronously
// Notes: pads pass two flip-flops, all pad and routing outputs are registered
module pmx_pin_mux (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] port0_pin_in,
	input wire logic [7:0] port1_pin_in,
	input wire logic [4:0] port2_pin_in,
	output logic [7:0] port0_pin_out,
	output logic [7:0] port0_pin_oe,
	output logic [7:0] port1_pin_out,
	output logic [7:0] port1_pin_oe,
	output logic [4:0] port2_pin_out,
	output logic [4:0] port2_pin_oe,
	input wire logic [7:0] port0_gpio_out,
	input wire logic [7:0] port1_gpio_out,
	input wire logic [4:0] port2_gpio_out,
	output logic [7:0] port0_gpio_in,
	output logic [7:0] port1_gpio_in,
	output logic [4:0] port2_gpio_in,
	input wire logic [7:0] port0_function_select,
	input wire logic [7:0] port1_function_select,
	input wire logic [4:0] port2_function_select,
	input wire logic [7:0] port0_direction,
	input wire logic [7:0] port1_direction,
	input wire logic [4:0] port2_direction,
	input wire logic [1:0] port0_priority_field,
	input wire logic port1_priority_bit3,
	input wire logic port1_priority_bit2,
	input wire logic port1_priority_bit1,
	input wire logic port1_priority_bit0,
	input wire logic serial_a_location_bit,
	input wire logic serial_b_location_bit,
	input wire logic timer_one_location_bit,
	input wire logic timer_three_location_bit,
	input wire logic timer_four_location_bit,
	input wire logic [7:0] analog_input_enable,
	input wire logic audio_serial_enable,
	input wire logic audio_serial_location,
	input wire logic debug_enable,
	input wire logic serial_a_enable,
	input wire logic serial_a_uart_mode,
	input wire logic serial_a_flow_control,
	input wire logic [3:0] serial_a_out,
	input wire logic [3:0] serial_a_oe,
	output logic [3:0] serial_a_in,
	input wire logic serial_b_enable,
	input wire logic serial_b_uart_mode,
	input wire logic serial_b_flow_control,
	input wire logic [3:0] serial_b_out,
	input wire logic [3:0] serial_b_oe,
	output logic [3:0] serial_b_in,
	input wire logic timer_one_enable,
	input wire logic [2:0] timer_one_out,
	input wire logic [2:0] timer_one_oe,
	output logic [2:0] timer_one_in,
	input wire logic timer_three_enable,
	input wire logic [1:0] timer_three_out,
	input wire logic [1:0] timer_three_oe,
	input wire logic timer_four_enable,
	input wire logic [1:0] timer_four_out,
	input wire logic [1:0] timer_four_oe,
	input wire logic [3:0] audio_out,
	input wire logic [3:0] audio_oe,
	output logic [3:0] audio_in,
	input wire logic debug_data_out,
	input wire logic debug_data_oe,
	output logic debug_data_in,
	output logic debug_clock_in,
	input wire logic [1:0] sleep_mode,
	input wire logic port0_irq_request,
	input wire logic port1_irq_request,
	input wire logic port2_irq_request,
	output logic port0_irq,
	output logic port1_irq,
	output logic port2_irq,
	output logic pin_dma_trigger_a,
	output logic pin_dma_trigger_b
);
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_raw, sel_flat, dir_flat, gpio_flat, analog_flat;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_sync, pin_prev;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] audio_own, debug_own, gpio_input;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_out, pin_oe, next_pin_out, next_pin_oe;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0][1:0] audio_slot;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0][pmx_pkg::PMX_PERIPH_COUNT-1:0] claim, owner;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0][pmx_pkg::PMX_PERIPH_COUNT-1:0][1:0] slot_of;
	logic [pmx_pkg::PMX_PERIPH_COUNT-1:0][pmx_pkg::PMX_SLOT_COUNT-1:0] per_out, per_oe;
	logic [pmx_pkg::PMX_PERIPH_COUNT-1:0][pmx_pkg::PMX_SLOT_COUNT-1:0] per_in, next_per_in;
	logic [pmx_pkg::PMX_PERIPH_COUNT-1:0] per_en, per_alt;
	logic [1:0] uart_bare;
	pmx_pkg::pmx_beat_t beat_p0, beat_p1;
	pmx_pkg::pmx_pin_t map_pin, apin;
	logic [3:0] audio_in_q, next_audio_in;
	logic dbg_data_q, next_dbg_data, dbg_clk_q, next_dbg_clk;
	logic trig_a, trig_b, next_trig_a, next_trig_b;
	logic [2:0] irq, next_irq;

	// one-hot winner among claimants; beat[i][j] set means i wins over j
	function automatic logic [pmx_pkg::PMX_PERIPH_COUNT-1:0] pmx_resolve(
		input logic [pmx_pkg::PMX_PERIPH_COUNT-1:0] mask,
		input pmx_pkg::pmx_beat_t beat);
		logic [pmx_pkg::PMX_PERIPH_COUNT-1:0] win;
		logic ok;
		win = '0;
		for (int i = 0; i < pmx_pkg::PMX_PERIPH_COUNT; i++) begin
			ok = mask[i];
			for (int j = 0; j < pmx_pkg::PMX_PERIPH_COUNT; j++) begin
				if (j != i && mask[j] && !beat[i][j]) begin
					ok = 1'b0;
				end
			end
			if (ok && win == '0) begin
				win[i] = 1'b1;
			end
		end
		// circular three-way claims: lowest-numbered claimant keeps the pin
		for (int i = 0; i < pmx_pkg::PMX_PERIPH_COUNT; i++) begin
			if (mask[i] && win == '0) begin
				win[i] = 1'b1;
			end
		end
		return win;
	endfunction

	pmx_pin_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pin_raw(pin_raw),
		.pin_sync(pin_sync),
		.pin_prev(pin_prev)
	);

	assign pin_raw = {port2_pin_in, port1_pin_in, port0_pin_in};
	assign sel_flat = {port2_function_select, port1_function_select, port0_function_select};
	assign dir_flat = {port2_direction, port1_direction, port0_direction};
	assign gpio_flat = {port2_gpio_out, port1_gpio_out, port0_gpio_out};
	assign analog_flat = {13'h0000, analog_input_enable};
	assign per_out = {{2'h0, timer_four_out}, {2'h0, timer_three_out}, {1'b0, timer_one_out},
		serial_b_out, serial_a_out};
	assign per_oe = {{2'h0, timer_four_oe}, {2'h0, timer_three_oe}, {1'b0, timer_one_oe},
		serial_b_oe, serial_a_oe};
	assign per_en = {timer_four_enable, timer_three_enable, timer_one_enable,
		serial_b_enable, serial_a_enable};
	assign per_alt = {timer_four_location_bit, timer_three_location_bit, timer_one_location_bit,
		serial_b_location_bit, serial_a_location_bit};
	assign uart_bare = {serial_b_uart_mode && !serial_b_flow_control,
		serial_a_uart_mode && !serial_a_flow_control};

	always_comb begin
		beat_p0 = '1;
		beat_p1 = '1;
		beat_p0[pmx_pkg::PMX_SERIAL_A][pmx_pkg::PMX_SERIAL_B] =
			port0_priority_field != pmx_pkg::PMX_P0_SERIAL_B_FIRST;
		beat_p0[pmx_pkg::PMX_SERIAL_A][pmx_pkg::PMX_TIMER_ONE] =
			port0_priority_field != pmx_pkg::PMX_P0_TIMER_OVER_A;
		beat_p0[pmx_pkg::PMX_SERIAL_B][pmx_pkg::PMX_TIMER_ONE] =
			port0_priority_field != pmx_pkg::PMX_P0_TIMER_OVER_B;
		beat_p1[pmx_pkg::PMX_SERIAL_A][pmx_pkg::PMX_SERIAL_B] =
			!port1_priority_bit3;
		beat_p1[pmx_pkg::PMX_SERIAL_A][pmx_pkg::PMX_TIMER_ONE] =
			!port1_priority_bit0;
		beat_p1[pmx_pkg::PMX_SERIAL_B][pmx_pkg::PMX_TIMER_THREE] =
			!port1_priority_bit2;
		beat_p1[pmx_pkg::PMX_TIMER_ONE][pmx_pkg::PMX_TIMER_FOUR] =
			!port1_priority_bit1;
		for (int i = 0; i < pmx_pkg::PMX_PERIPH_COUNT; i++) begin
			for (int j = i + 1; j < pmx_pkg::PMX_PERIPH_COUNT; j++) begin
				beat_p0[j][i] = !beat_p0[i][j];
				beat_p1[j][i] = !beat_p1[i][j];
			end
		end
	end

	always_comb begin
		claim = '0;
		slot_of = '0;
		audio_own = '0;
		audio_slot = '0;
		debug_own = '0;
		map_pin = pmx_pkg::PMX_PIN_NONE;
		apin = pmx_pkg::PMX_PIN_NONE;
		for (int p = 0; p < pmx_pkg::PMX_PERIPH_COUNT; p++) begin
			for (int s = 0; s < pmx_pkg::PMX_SLOT_COUNT; s++) begin
				map_pin = pmx_pkg::PMX_PIN_MAP[p][per_alt[p]][s];
				// bare UART leaves its flow-control pins free
				if (map_pin != pmx_pkg::PMX_PIN_NONE && per_en[p] &&
					!(p < 2 && uart_bare[p] && s >= pmx_pkg::PMX_UART_FLOW_SLOT)) begin
					if (sel_flat[map_pin] && !analog_flat[map_pin]) begin
						claim[map_pin][p] = 1'b1;
						slot_of[map_pin][p] = 2'(s);
					end
				end
			end
		end
		for (int s = 0; s < pmx_pkg::PMX_SLOT_COUNT; s++) begin
			apin = pmx_pkg::PMX_AUDIO_MAP[audio_serial_location][s];
			audio_own[apin] = audio_serial_enable;
			audio_slot[apin] = 2'(s);
		end
		debug_own[pmx_pkg::PMX_DEBUG_DATA_PIN] = debug_enable;
		debug_own[pmx_pkg::PMX_DEBUG_CLOCK_PIN] = debug_enable;

		for (int k = 0; k < pmx_pkg::PMX_PIN_COUNT; k++) begin
			if (k < pmx_pkg::PMX_P1_BASE) begin
				owner[k] = pmx_resolve(claim[k], beat_p0);
			end else begin
				owner[k] = pmx_resolve(claim[k], beat_p1);
			end
			next_pin_out[k] = gpio_flat[k];
			next_pin_oe[k] = dir_flat[k];
			for (int p = 0; p < pmx_pkg::PMX_PERIPH_COUNT; p++) begin
				if (owner[k][p]) begin
					next_pin_out[k] = per_out[p][slot_of[k][p]];
					next_pin_oe[k] = per_oe[p][slot_of[k][p]];
				end
			end
			if (analog_flat[k]) begin
				next_pin_out[k] = 1'b0;
				next_pin_oe[k] = 1'b0;
			end
			if (audio_own[k]) begin
				next_pin_out[k] = audio_out[audio_slot[k]];
				next_pin_oe[k] = audio_oe[audio_slot[k]];
			end
			if (debug_own[k]) begin
				next_pin_out[k] = (k == pmx_pkg::PMX_DEBUG_DATA_PIN) && debug_data_out;
				next_pin_oe[k] = (k == pmx_pkg::PMX_DEBUG_DATA_PIN) && debug_data_oe;
			end
			gpio_input[k] = !sel_flat[k] && !dir_flat[k] && !analog_flat[k] &&
				!audio_own[k] && !debug_own[k];
		end

		next_per_in = '0;
		for (int p = 0; p < pmx_pkg::PMX_PERIPH_COUNT; p++) begin
			for (int s = 0; s < pmx_pkg::PMX_SLOT_COUNT; s++) begin
				map_pin = pmx_pkg::PMX_PIN_MAP[p][per_alt[p]][s];
				if (map_pin != pmx_pkg::PMX_PIN_NONE) begin
					next_per_in[p][s] = owner[map_pin][p] && !audio_own[map_pin] &&
						!debug_own[map_pin] && pin_sync[map_pin];
				end
			end
		end
		for (int s = 0; s < pmx_pkg::PMX_SLOT_COUNT; s++) begin
			apin = pmx_pkg::PMX_AUDIO_MAP[audio_serial_location][s];
			next_audio_in[s] = audio_own[apin] && !debug_own[apin] && pin_sync[apin];
		end
		next_dbg_data = debug_enable && pin_sync[pmx_pkg::PMX_DEBUG_DATA_PIN];
		next_dbg_clk = debug_enable && pin_sync[pmx_pkg::PMX_DEBUG_CLOCK_PIN];

		next_trig_a = pin_sync[pmx_pkg::PMX_TRIG_A_PIN] && !pin_prev[pmx_pkg::PMX_TRIG_A_PIN] &&
			gpio_input[pmx_pkg::PMX_TRIG_A_PIN];
		next_trig_b = !pin_sync[pmx_pkg::PMX_TRIG_B_PIN] && pin_prev[pmx_pkg::PMX_TRIG_B_PIN] &&
			gpio_input[pmx_pkg::PMX_TRIG_B_PIN];
		next_irq = {port2_irq_request, port1_irq_request, port0_irq_request} &
			{3{sleep_mode == pmx_pkg::PMX_SLEEP_ACTIVE}};
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out <= pmx_pkg::PMX_PIN_RESET;
			pin_oe <= pmx_pkg::PMX_PIN_RESET;
			per_in <= '0;
			audio_in_q <= 4'h0;
			dbg_data_q <= 1'b0;
			dbg_clk_q <= 1'b0;
			trig_a <= 1'b0;
			trig_b <= 1'b0;
			irq <= 3'h0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			per_in <= next_per_in;
			audio_in_q <= next_audio_in;
			dbg_data_q <= next_dbg_data;
			dbg_clk_q <= next_dbg_clk;
			trig_a <= next_trig_a;
			trig_b <= next_trig_b;
			irq <= next_irq;
		end
	end

	assign port0_pin_out = pin_out[7:0];
	assign port0_pin_oe = pin_oe[7:0];
	assign port1_pin_out = pin_out[15:8];
	assign port1_pin_oe = pin_oe[15:8];
	assign port2_pin_out = pin_out[20:16];
	assign port2_pin_oe = pin_oe[20:16];
	assign port0_gpio_in = pin_sync[7:0];
	assign port1_gpio_in = pin_sync[15:8];
	assign port2_gpio_in = pin_sync[20:16];
	assign serial_a_in = per_in[pmx_pkg::PMX_SERIAL_A];
	assign serial_b_in = per_in[pmx_pkg::PMX_SERIAL_B];
	assign timer_one_in = per_in[pmx_pkg::PMX_TIMER_ONE][2:0];
	assign audio_in = audio_in_q;
	assign debug_data_in = dbg_data_q;
	assign debug_clock_in = dbg_clk_q;
	assign pin_dma_trigger_a = trig_a;
	assign pin_dma_trigger_b = trig_b;
	assign port0_irq = irq[0];
	assign port1_irq = irq[1];
	assign port2_irq = irq[2];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_irq_sleep_gate: assert property ((sleep_mode != 2'h0) |=> !(port0_irq || port1_irq || port2_irq))
		else $error("port interrupt passed while asleep");
	a_trig_a_cause: assert property (pin_dma_trigger_a |-> $past(pin_sync[1]) && !$past(pin_prev[1])
		&& !$past(port0_function_select[1]) && !$past(port0_direction[1]))
		else $error("trigger A without a rising edge on a GPIO input");
	a_trig_b_cause: assert property (pin_dma_trigger_b |-> !$past(pin_sync[11]) && $past(pin_prev[11])
		&& !$past(port1_function_select[3]) && !$past(port1_direction[3]))
		else $error("trigger B without a falling edge on a GPIO input");
	a_trig_a_fires: assert property ((pin_sync[1] && !pin_prev[1] && !port0_function_select[1]
		&& !port0_direction[1] && !analog_input_enable[1] && !audio_serial_enable)
		|=> pin_dma_trigger_a)
		else $error("trigger A missed on a GPIO input edge");
	a_gpio_fallback: assert property ((!analog_input_enable[6] && !audio_serial_enable) |=>
		port0_pin_out[6] == $past(port0_gpio_out[6]) && port0_pin_oe[6] == $past(port0_direction[6]))
		else $error("unclaimed pin does not follow GPIO");
	a_p0_serial_a_wins: assert property ((port0_priority_field == 2'h0 && serial_a_enable
		&& serial_b_enable && !serial_a_location_bit && !serial_b_location_bit && !serial_a_uart_mode
		&& port0_function_select[5] && !analog_input_enable[5] && !audio_serial_enable)
		|=> port0_pin_out[5] == $past(serial_a_out[3]))
		else $error("serial A lost pin 5 under priority 00");
	a_p0_serial_b_wins: assert property ((port0_priority_field == 2'h1 && serial_a_enable
		&& serial_b_enable && !serial_a_location_bit && !serial_b_location_bit
		&& port0_function_select[5] && !analog_input_enable[5] && !audio_serial_enable)
		|=> port0_pin_out[5] == $past(serial_b_out[0]))
		else $error("serial B lost pin 5 under priority 01");
	a_p0_uart_release: assert property ((port0_priority_field == 2'h0 && serial_a_enable
		&& serial_a_uart_mode && !serial_a_flow_control && serial_b_enable && !timer_one_enable
		&& !serial_a_location_bit && !serial_b_location_bit && port0_function_select[4]
		&& !analog_input_enable[4] && !audio_serial_enable)
		|=> port0_pin_out[4] == $past(serial_b_out[1]))
		else $error("bare UART serial A kept pin 4");
	a_p1_timer_order: assert property ((timer_one_enable && timer_one_location_bit
		&& timer_four_enable && !timer_four_location_bit && port1_function_select[0])
		|=> port1_pin_out[0] == $past(port1_priority_bit1 ? timer_four_out[0] : timer_one_out[2]))
		else $error("wrong timer owns port 1 pin 0");
	a_audio_override: assert property ((audio_serial_enable && !audio_serial_location) |=>
		port0_pin_out[1] == $past(audio_out[0]) && port0_pin_oe[1] == $past(audio_oe[0]))
		else $error("audio serial lost its clock pin");
	a_analog_override: assert property ((analog_input_enable[2] && !audio_serial_enable)
		|=> !port0_pin_oe[2])
		else $error("analog pin still driven");
endmodule // pmx_pin_mux

// [shared/pmx_pkg.sv]
// Purpose: constants, pin map and types shared by the pin multiplexer files
// Assumes: pins are numbered flat, port 0 at 0..7, port 1 at 8..15, port 2 at 16..20
// Notes: peripheral signal slots keep one pin per slot except unused timer slots and the flow-control slots of a bare UART
package pmx_pkg;
	localparam int PMX_PIN_COUNT = 21;
	localparam int PMX_P1_BASE = 8;
	localparam int PMX_PERIPH_COUNT = 5;
	localparam int PMX_SLOT_COUNT = 4;
	// serial slots from here on carry the flow-control signals
	localparam int PMX_UART_FLOW_SLOT = 2;

	localparam int PMX_SERIAL_A = 0;
	localparam int PMX_SERIAL_B = 1;
	localparam int PMX_TIMER_ONE = 2;
	localparam int PMX_TIMER_THREE = 3;
	localparam int PMX_TIMER_FOUR = 4;

	typedef logic [4:0] pmx_pin_t;
	typedef logic [PMX_PERIPH_COUNT-1:0][PMX_PERIPH_COUNT-1:0] pmx_beat_t;

	localparam pmx_pin_t PMX_PIN_NONE = 5'h1F;
	localparam pmx_pin_t PMX_TRIG_A_PIN = 5'h01;
	localparam pmx_pin_t PMX_TRIG_B_PIN = 5'h0B;
	localparam pmx_pin_t PMX_DEBUG_DATA_PIN = 5'h11;
	localparam pmx_pin_t PMX_DEBUG_CLOCK_PIN = 5'h12;

	localparam logic [1:0] PMX_P0_SERIAL_A_FIRST = 2'h0;
	localparam logic [1:0] PMX_P0_SERIAL_B_FIRST = 2'h1;
	localparam logic [1:0] PMX_P0_TIMER_OVER_B = 2'h2;
	localparam logic [1:0] PMX_P0_TIMER_OVER_A = 2'h3;
	localparam logic [1:0] PMX_SLEEP_ACTIVE = 2'h0;

	localparam logic [PMX_PIN_COUNT-1:0] PMX_SYNC_RESET = 21'h1FFFFF;
	localparam logic [PMX_PIN_COUNT-1:0] PMX_PIN_RESET = 21'h000000;

	// pin of each slot: [peripheral][location][slot]
	// serial slots: 0 MISO/RX, 1 MOSI/TX, 2 SS/CTS, 3 SCK/RTS; timer slots are channels
	localparam pmx_pin_t PMX_PIN_MAP [PMX_PERIPH_COUNT][2][PMX_SLOT_COUNT] = '{
		'{'{5'h02, 5'h03, 5'h04, 5'h05}, '{5'h0C, 5'h0D, 5'h0A, 5'h0B}},
		'{'{5'h05, 5'h04, 5'h02, 5'h03}, '{5'h0F, 5'h0E, 5'h0C, 5'h0D}},
		'{'{5'h02, 5'h03, 5'h04, 5'h1F}, '{5'h0A, 5'h09, 5'h08, 5'h1F}},
		'{'{5'h0B, 5'h0C, 5'h1F, 5'h1F}, '{5'h0E, 5'h0F, 5'h1F, 5'h1F}},
		'{'{5'h08, 5'h09, 5'h1F, 5'h1F}, '{5'h10, 5'h13, 5'h1F, 5'h1F}}
	};
	// audio slots: 0 clock, 1 word select, 2 data in, 3 data out
	localparam pmx_pin_t PMX_AUDIO_MAP [2][PMX_SLOT_COUNT] = '{
		'{5'h01, 5'h00, 5'h0F, 5'h0E},
		'{5'h13, 5'h12, 5'h11, 5'h10}
	};
endpackage

// [verilog/pmx_pin_sync.sv]
// Purpose: two-stage synchroniser for all pad inputs plus one delayed copy
// Assumes: pads are asynchronous to clk
// Notes: pin_prev lags pin_sync by one cycle for edge detection
module pmx_pin_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_raw,
	output logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_sync,
	output logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_prev
);
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] pin_meta;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] next_pin_meta;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] next_pin_sync;
	logic [pmx_pkg::PMX_PIN_COUNT-1:0] next_pin_prev;

	always_comb begin
		next_pin_meta = pin_raw;
		next_pin_sync = pin_meta;
		next_pin_prev = pin_sync;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= pmx_pkg::PMX_SYNC_RESET;
			pin_sync <= pmx_pkg::PMX_SYNC_RESET;
			pin_prev <= pmx_pkg::PMX_SYNC_RESET;
		end else begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
			pin_prev <= next_pin_prev;
		end
	end
endmodule // pmx_pin_sync

// [bench/pmx_pad_model.sv]
// Purpose: pads seen from outside, each pin drives back what the block drives
// Assumes: undriven pins settle to the level asked for by the bench
// Notes: pad levels default to ones, as with the input pull-ups
module pmx_pad_model (
	input wire logic [7:0] port0_pin_out,
	input wire logic [7:0] port0_pin_oe,
	input wire logic [7:0] port1_pin_out,
	input wire logic [7:0] port1_pin_oe,
	input wire logic [4:0] port2_pin_out,
	input wire logic [4:0] port2_pin_oe,
	input wire logic [7:0] pad0,
	input wire logic [7:0] pad1,
	input wire logic [4:0] pad2,
	output logic [7:0] port0_pin_in,
	output logic [7:0] port1_pin_in,
	output logic [4:0] port2_pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	assign port0_pin_in = (port0_pin_oe & port0_pin_out) | (~port0_pin_oe & pad0);
	assign port1_pin_in = (port1_pin_oe & port1_pin_out) | (~port1_pin_oe & pad1);
	assign port2_pin_in = (port2_pin_oe & port2_pin_out) | (~port2_pin_oe & pad2);
endmodule // pmx_pad_model

// [bench/test_peripheral_pin_mux_priority.sv]
// Purpose: ownership, routing, dma triggers and irq gating of the pin mux
// Assumes: outputs settle one edge after their inputs, pads three edges later
// Notes: ports hook up by matching names
module test_peripheral_pin_mux_priority;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_b = 0;
	logic [7:0] port0_pin_in, port1_pin_in, port0_pin_out, port0_pin_oe, port1_pin_out,
		port1_pin_oe, port0_gpio_out, port1_gpio_out, port0_gpio_in, port1_gpio_in,
		port0_function_select, port1_function_select, port0_direction, port1_direction,
		analog_input_enable, pad0, pad1, cnt_a, cnt_b;
	logic [4:0] port2_pin_in, port2_pin_out, port2_pin_oe, port2_gpio_out, port2_gpio_in,
		port2_function_select, port2_direction, pad2;
	logic [3:0] serial_a_out, serial_a_oe, serial_a_in, serial_b_out, serial_b_oe,
		serial_b_in, audio_out, audio_oe, audio_in;
	logic [2:0] timer_one_out, timer_one_oe, timer_one_in;
	logic [1:0] port0_priority_field, timer_three_out, timer_three_oe, timer_four_out,
		timer_four_oe, sleep_mode;
	logic port1_priority_bit3, port1_priority_bit2, port1_priority_bit1, port1_priority_bit0,
		serial_a_location_bit, serial_b_location_bit, timer_one_location_bit,
		timer_three_location_bit, timer_four_location_bit, audio_serial_enable,
		audio_serial_location, debug_enable, serial_a_enable, serial_a_uart_mode,
		serial_a_flow_control, serial_b_enable, serial_b_uart_mode, serial_b_flow_control,
		timer_one_enable, timer_three_enable, timer_four_enable, debug_data_out, debug_data_oe,
		debug_data_in, debug_clock_in, port0_irq_request, port1_irq_request, port2_irq_request,
		port0_irq, port1_irq, port2_irq, pin_dma_trigger_a, pin_dma_trigger_b;
	int errors = 0, checked = 0;
	localparam logic [3:0] P0_EXP [4] = '{4'h0, 4'hF, 4'hC, 4'hC};
	localparam logic [3:0] P1_PRI [3] = '{4'h0, 4'h8, 4'h7};
	localparam logic [7:0] P1_EXP [3] = '{8'hC3, 8'hF3, 8'h04};
	always #5 clk = ~clk;
	pmx_pin_mux i_pmx_pin_mux (.*);
	pmx_pad_model i_pmx_pad_model (.*);
	always @(posedge clk) begin
		if (pin_dma_trigger_a === 1'b1) cnt_a <= cnt_a + 8'h01;
		if (pin_dma_trigger_b === 1'b1) cnt_b <= cnt_b + 8'h01;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic clear;
		{port0_gpio_out, port1_gpio_out, port2_gpio_out, port0_function_select,
			port1_function_select, port2_function_select, port0_direction, port1_direction,
			port2_direction, port0_priority_field, port1_priority_bit3, port1_priority_bit2,
			port1_priority_bit1, port1_priority_bit0, serial_a_location_bit,
			serial_b_location_bit, timer_one_location_bit, timer_three_location_bit,
			timer_four_location_bit, analog_input_enable, audio_serial_enable,
			audio_serial_location, debug_enable, serial_a_enable, serial_a_uart_mode,
			serial_a_flow_control, serial_a_out, serial_a_oe, serial_b_enable, serial_b_uart_mode,
			serial_b_flow_control, serial_b_out, serial_b_oe, timer_one_enable, timer_one_out,
			timer_one_oe, timer_three_enable, timer_three_out, timer_three_oe, timer_four_enable,
			timer_four_out, timer_four_oe, audio_out, audio_oe, debug_data_out, debug_data_oe,
			sleep_mode, port0_irq_request, port1_irq_request, port2_irq_request} <= '0;
		{pad0, pad1, pad2} <= '1;
	endtask
	task automatic conclude;
		if (errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#500us;
		errors++;
		conclude;
	end
	initial begin
		clear;
		step(4);
		check("p0 oe in reset", port0_pin_oe, 8'h00);
		@(posedge clk);
		rst_b <= 1'b1;
		port0_function_select <= 8'h20;
		port0_direction <= 8'h20;
		serial_a_enable <= 1'b1;
		serial_a_out <= 4'h8;
		serial_a_oe <= 4'h8;
		step(3);
		check("p0_5 serial", {port0_pin_out[5], port0_pin_oe[5]}, 2'h3);
		analog_input_enable <= 8'h20;
		step(2);
		check("p0_5 analog", port0_pin_oe[5], 1'b0);
		analog_input_enable <= 8'h00;
		port0_function_select <= 8'h00;
		step(2);
		check("p0_5 gpio", {port0_pin_out[5], port0_pin_oe[5]}, 2'h1);
		clear;
		{serial_a_enable, serial_b_enable} <= 2'h3;
		{serial_a_oe, serial_b_oe, serial_b_out} <= 12'hFFF;
		port0_function_select <= 8'h3C;
		for (int i = 0; i < 4; i++) begin
			port0_priority_field <= {1'b0, i[0]};
			serial_a_uart_mode <= (i == 2);
			serial_b_uart_mode <= (i == 3);
			step(2);
			check("p0 serial", port0_pin_out[5:2], P0_EXP[i]);
		end
		clear;
		port0_function_select <= 8'h3C;
		{timer_one_enable, timer_one_out, timer_one_oe} <= 7'h7F;
		{serial_a_oe, serial_b_oe} <= 8'hFF;
		for (int i = 0; i < 2; i++) begin
			port0_priority_field <= {1'b1, i[0]};
			serial_b_enable <= (i == 0);
			serial_a_enable <= (i == 1);
			step(2);
			check("p0 timer", port0_pin_out[4:2], 3'h7);
		end
		clear;
		{port0_function_select, port1_function_select} <= 16'hFFFF;
		{serial_a_location_bit, serial_a_enable, serial_a_out, serial_a_oe} <= 10'h3FF;
		step(2);
		check("p1 alt2", port1_pin_out, 8'h3C);
		check("p0 alt1 idle", port0_pin_oe, 8'h00);
		clear;
		// serial b kept in spi mode, no pin carries three claims
		port1_function_select <= 8'hFF;
		{serial_a_enable, serial_b_enable, timer_one_enable} <= 3'h7;
		{timer_three_enable, timer_four_enable} <= 2'h3;
		{serial_a_location_bit, serial_b_location_bit} <= 2'h3;
		{timer_one_location_bit, timer_three_location_bit} <= 2'h3;
		{serial_b_out, timer_one_out, serial_a_oe, serial_b_oe, timer_one_oe} <= 18'h3FFFF;
		{timer_three_oe, timer_four_oe} <= 4'hF;
		for (int i = 0; i < 3; i++) begin
			{port1_priority_bit3, port1_priority_bit2, port1_priority_bit1,
				port1_priority_bit0} <= P1_PRI[i];
			step(2);
			check("p1 owner", port1_pin_out, P1_EXP[i]);
		end
		clear;
		{audio_serial_enable, audio_out, audio_oe} <= 9'h111;
		port0_direction <= 8'h02;
		step(2);
		check("audio clock", {port0_pin_out[1], port0_pin_oe[1]}, 2'h3);
		clear;
		{port0_irq_request, port1_irq_request, port2_irq_request} <= 3'h7;
		for (int m = 0; m < 4; m++) begin
			sleep_mode <= 2'(m);
			step(2);
			check("irq", {port0_irq, port1_irq, port2_irq}, (m == 0) ? 3'h7 : 3'h0);
		end
		clear;
		pad0[1] <= 1'b0;
		step(6);
		{cnt_a, cnt_b} = '0;
		pad0[1] <= 1'b1;
		pad1[3] <= 1'b0;
		step(8);
		check("trigger a", cnt_a, 8'h01);
		check("trigger b", cnt_b, 8'h01);
		check("gpio in", {port0_gpio_in[1], port1_gpio_in[3]}, 2'h2);
		pad1[3] <= 1'b1;
		port0_direction <= 8'h02;
		port1_function_select <= 8'h08;
		step(6);
		{cnt_a, cnt_b} = '0;
		port0_gpio_out <= 8'h02;
		pad1[3] <= 1'b0;
		step(8);
		check("no trigger", {cnt_a[3:0], cnt_b[3:0]}, 8'h00);
		conclude;
	end
endmodule // test_peripheral_pin_mux_priority
